// ### rtl/gfw_pkg.sv
// constants, register map, tables and types for the gap-fill whitening and flag encoder
// assumes one clock domain, AXI4-Lite register access and a coder core on the same clock
// What this block does
// - clear filter states on start, switches, transients
// - clear current levels on start and switches
// - copy current levels to previous, then zero
// - force every level to one around transients
// - tile ratios; tile starts accumulate tile widths
// - smooth ratio with filter states, cap 2.7
// - map smoothed value to tile level
// - mirror second-last level into last where tabled
// - send each tile level in one or two bits
// - dependent frame: one if unchanged, else zero
// - tile zero, then change flag and remaining tiles
// - level code: one→0, zero→10, other→11
// - prediction gain from eight reflection coefficients
// - temporal flat when both gains below 1.15
// - independent frame resets scale factor coder state
// - zero flag first; if set, reset, stop
// - state is history valid bit plus vector
// - invalid history on dependent frame codes independently
// - raw values go out bitwise, most significant first
// - tile count comes from configuration table

package gfw_pkg;
	localparam int NT_MAX = 4;
	localparam int NB_MAX = 16;
	localparam int NPAR   = 8;
	localparam int NCFG   = 15;

	// ****************************************************
	// register word indices (byte address is four times)
	// ****************************************************
	localparam logic [5:0] A_CTRL   = 6'h00;
	localparam logic [5:0] A_CFG    = 6'h01;
	localparam logic [5:0] A_FLAGS  = 6'h02;
	localparam logic [5:0] A_STATUS = 6'h03;
	localparam logic [5:0] A_THR    = 6'h04;
	localparam logic [5:0] A_GEOM   = 6'h05;
	localparam logic [5:0] A_WIDTH  = 6'h06;
	localparam logic [5:0] A_TNS    = 6'h07;
	localparam logic [5:0] A_RAW    = 6'h08;
	localparam logic [5:0] A_SCF    = 6'h09;
	localparam logic [5:0] A_RATIO  = 6'h0A;
	localparam logic [5:0] A_PARCOR = 6'h0E;
	localparam logic [5:0] A_TSTART = 6'h16;

	// ****************************************************
	// field positions
	// ****************************************************
	localparam int CTRL_WHITEN = 0;
	localparam int CTRL_FLAT   = 1;
	localparam int CTRL_SCF    = 2;
	localparam int CTRL_RAW    = 3;
	localparam int FL_TRANS    = 0;
	localparam int FL_P2T      = 1;
	localparam int FL_INDEP    = 2;
	localparam int FL_POWER    = 3;

	// ****************************************************
	// reset values and fixed-point thresholds
	// ****************************************************
	localparam logic [4:0]  CFG_RST    = 5'h00;
	localparam logic [15:0] THR_LO_RST = 16'h0800;
	localparam logic [15:0] THR_HI_RST = 16'h1800;
	localparam logic [15:0] S_CAP      = 16'h2B33;
	localparam logic [16:0] PROD_ONE   = 17'h08000;
	localparam logic [16:0] PROD_THR   = 17'h06F4E;
	localparam logic [15:0] TNS_THR    = 16'h1267;
	localparam logic [1:0]  RESP_OK    = 2'h0;
	localparam logic [1:0]  RESP_ERR   = 2'h2;

	// per-configuration tile count and last-tile mirroring
	localparam logic [2:0] CFG_TILES [NCFG] = '{
		3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h3, 3'h1, 3'h1,
		3'h3, 3'h4, 3'h4, 3'h1, 3'h1, 3'h1, 3'h1};
	localparam logic [NCFG-1:0] CFG_MIRROR = 15'h073B;

	typedef enum logic [2:0] {OP_START, OP_SIGN, OP_WBIT, OP_VECTOR, OP_FINISH} gfw_op_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_SEND, ST_FMUL, ST_FEVAL, ST_SSTART, ST_SZERO, ST_SVEC, ST_SFIN
	} gfw_st_t;
	typedef struct packed {
		gfw_op_t op;
		logic    bit_val;
		logic    hist;
	} gfw_cod_t;
endpackage : gfw_pkg

// ### rtl/gfw_encoder.sv
// whitening level, flatness flag and scale-factor coder control for the gap-fill tool
// assumes an AXI4-Lite master and a coder core that takes one item per valid/ready beat
`timescale 1ns/1ps

module gfw_encoder (
	input  logic              aclk,
	input  logic              aresetn,
	input  logic [7:0]        awaddr,
	input  logic              awvalid,
	output logic              awready,
	input  logic [31:0]       wdata,
	input  logic [3:0]        wstrb,
	input  logic              wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  logic              bready,
	input  logic [7:0]        araddr,
	input  logic              arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  logic              rready,
	output logic              cod_valid,
	output gfw_pkg::gfw_cod_t cod,
	input  logic              cod_ready,
	output logic [111:0]      sf_cur,
	output logic [111:0]      sf_prev,
	output logic              temporal_flat_flag,
	output logic              zero_scale_flag
);
	import gfw_pkg::*;

	// ****************************************************
	// software registers
	// ****************************************************
	logic        aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
	logic [5:0]  aw_a_r, aw_a_nxt;
	logic [31:0] w_d_r, w_d_nxt;
	logic [3:0]  w_s_r, w_s_nxt;
	logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [3:0]  cmd_r, cmd_nxt;
	logic        cfg_chg_r, cfg_chg_nxt;
	logic [4:0]  cfg_r, cfg_nxt;
	logic [3:0]  flags_r, flags_nxt;
	logic [15:0] thr_lo_r, thr_lo_nxt, thr_hi_r, thr_hi_nxt, tns_r, tns_nxt;
	logic [9:0]  first_r, first_nxt;
	logic [4:0]  nb_r, nb_nxt;
	logic [31:0] width_r, width_nxt;
	logic [20:0] raw_r, raw_nxt;
	logic [15:0] ratio_r [NT_MAX];
	logic [15:0] ratio_nxt [NT_MAX];
	logic [15:0] parcor_r [NPAR];
	logic [15:0] parcor_nxt [NPAR];
	logic [6:0]  scf_r [NB_MAX];
	logic [6:0]  scf_nxt [NB_MAX];
	logic [9:0]  tstart [NT_MAX];
	logic [31:0] wmask, wnew;
	logic [32:0] wold, rd_ar;

	// ****************************************************
	// core state
	// ****************************************************
	gfw_st_t     st_r, st_nxt;
	gfw_cod_t    cod_r, cod_nxt;
	logic        cod_valid_r, cod_valid_nxt;
	logic [15:0] fir_r [NT_MAX];
	logic [15:0] fir_nxt [NT_MAX];
	logic [15:0] iir_r [NT_MAX];
	logic [15:0] iir_nxt [NT_MAX];
	logic [1:0]  cur_r [NT_MAX];
	logic [1:0]  cur_nxt [NT_MAX];
	logic [1:0]  prevl_r [NT_MAX];
	logic [1:0]  prevl_nxt [NT_MAX];
	logic [6:0]  pscf_r [NB_MAX];
	logic [6:0]  pscf_nxt [NB_MAX];
	logic        prior_r, prior_nxt, hist_r, hist_nxt, flat_r, flat_nxt, zero_r, zero_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic [4:0]  shn_r, shn_nxt;
	logic [16:0] prod_r, prod_nxt;
	logic [2:0]  idx_r, idx_nxt;
	logic [1:0]  lv [NT_MAX];
	logic [2:0]  tc;
	logic        mirror, same, diff, w_go;
	logic [17:0] sm;
	logic [15:0] s_k, f_eff, i_eff;
	logic [31:0] kk;
	logic [16:0] om;
	logic [33:0] pm;

	function automatic logic [32:0] rd_word(input logic [5:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		if (a == A_CFG) r[31:0] = {27'h0, cfg_r};
		else if (a == A_FLAGS) r[31:0] = {28'h0, flags_r};
		else if (a == A_STATUS) r[31:0] = {8'h0, prevl_r[3], prevl_r[2], prevl_r[1],
			prevl_r[0], cur_r[3], cur_r[2], cur_r[1], cur_r[0], 3'h0, prior_r, hist_r,
			zero_r, flat_r, (st_r != ST_IDLE)};
		else if (a == A_THR) r[31:0] = {thr_hi_r, thr_lo_r};
		else if (a == A_GEOM) r[31:0] = {11'h0, nb_r, 6'h0, first_r};
		else if (a == A_WIDTH) r[31:0] = width_r;
		else if (a == A_TNS) r[31:0] = {16'h0, tns_r};
		else if (a == A_RAW) r[31:0] = {11'h0, raw_r};
		else if (a >= A_RATIO && a < A_PARCOR) r[31:0] = {16'h0, ratio_r[2'(a - A_RATIO)]};
		else if (a >= A_PARCOR && a < A_TSTART)
			r[31:0] = {16'h0, parcor_r[3'(a - A_PARCOR)]};
		else if (a == A_TSTART) r[31:0] = {6'h0, tstart[1], 6'h0, tstart[0]};
		else if (a == 6'h17) r[31:0] = {6'h0, tstart[3], 6'h0, tstart[2]};
		else if (a != A_CTRL && a != A_SCF) r[32] = 1'b0;
		return r;
	endfunction : rd_word

	function automatic logic [1:0] tiles_of(input logic [4:0] c);
		return (c[3:0] < 4'(NCFG)) ? 2'(CFG_TILES[c[3:0]] - 3'h1) : 2'h0;
	endfunction : tiles_of

	// ****************************************************
	// AXI4-Lite slave
	// ****************************************************
	always_comb begin
		aw_ok_nxt = aw_ok_r;
		aw_a_nxt = aw_a_r;
		w_ok_nxt = w_ok_r;
		w_d_nxt = w_d_r;
		w_s_nxt = w_s_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		arready_nxt = arready_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		cmd_nxt = 4'h0;
		cfg_chg_nxt = 1'b0;
		cfg_nxt = cfg_r;
		flags_nxt = flags_r;
		thr_lo_nxt = thr_lo_r;
		thr_hi_nxt = thr_hi_r;
		first_nxt = first_r;
		nb_nxt = nb_r;
		width_nxt = width_r;
		tns_nxt = tns_r;
		raw_nxt = raw_r;
		ratio_nxt = ratio_r;
		parcor_nxt = parcor_r;
		scf_nxt = scf_r;
		tstart[0] = first_r;
		for (int k = 1; k < NT_MAX; k++) begin
			tstart[k] = 10'(tstart[k-1] + {2'h0, width_r[8*k +: 8]});
		end
		wmask = {{8{w_s_r[3]}}, {8{w_s_r[2]}}, {8{w_s_r[1]}}, {8{w_s_r[0]}}};
		wold = rd_word(aw_a_r);
		wnew = (wold[31:0] & ~wmask) | (w_d_r & wmask);
		rd_ar = rd_word(araddr[7:2]);
		if (awvalid && !aw_ok_r && !bvalid_r) begin
			aw_ok_nxt = 1'b1;
			aw_a_nxt = awaddr[7:2];
		end
		if (wvalid && !w_ok_r && !bvalid_r) begin
			w_ok_nxt = 1'b1;
			w_d_nxt = wdata;
			w_s_nxt = wstrb;
		end
		if (aw_ok_r && w_ok_r) begin
			aw_ok_nxt = 1'b0;
			w_ok_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wold[32] ? RESP_OK : RESP_ERR;
			if (aw_a_r == A_CTRL) cmd_nxt = wnew[3:0];
			if (aw_a_r == A_CFG) begin
				cfg_nxt = wnew[4:0];
				cfg_chg_nxt = (wnew[4:0] != cfg_r);
			end
			if (aw_a_r == A_FLAGS) flags_nxt = wnew[3:0];
			if (aw_a_r == A_THR) {thr_hi_nxt, thr_lo_nxt} = wnew;
			if (aw_a_r == A_GEOM) {nb_nxt, first_nxt} = {wnew[20:16], wnew[9:0]};
			if (aw_a_r == A_WIDTH) width_nxt = wnew;
			if (aw_a_r == A_TNS) tns_nxt = wnew[15:0];
			if (aw_a_r == A_RAW) raw_nxt = wnew[20:0];
			// scale factor write: index in [3:0], value in [14:8]
			if (aw_a_r == A_SCF) scf_nxt[wnew[3:0]] = wnew[14:8];
			if (aw_a_r >= A_RATIO && aw_a_r < A_PARCOR)
				ratio_nxt[2'(aw_a_r - A_RATIO)] = wnew[15:0];
			if (aw_a_r >= A_PARCOR && aw_a_r < A_TSTART)
				parcor_nxt[3'(aw_a_r - A_PARCOR)] = wnew[15:0];
		end
		if (bvalid_r && bready) bvalid_nxt = 1'b0;
		if (arvalid && arready_r) begin
			arready_nxt = 1'b0;
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_ar[31:0];
			rresp_nxt = rd_ar[32] ? RESP_OK : RESP_ERR;
		end
		if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
			arready_nxt = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_r <= 1'b0;
			aw_a_r <= 6'h00;
			w_ok_r <= 1'b0;
			w_d_r <= 32'h0000_0000;
			w_s_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OK;
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OK;
			rdata_r <= 32'h0000_0000;
			cmd_r <= 4'h0;
			cfg_chg_r <= 1'b0;
			cfg_r <= CFG_RST;
			flags_r <= 4'h0;
			thr_lo_r <= THR_LO_RST;
			thr_hi_r <= THR_HI_RST;
			first_r <= 10'h000;
			nb_r <= 5'h00;
			width_r <= 32'h0000_0000;
			tns_r <= 16'h0000;
			raw_r <= 21'h00_0000;
			for (int k = 0; k < NT_MAX; k++) ratio_r[k] <= 16'h0000;
			for (int k = 0; k < NPAR; k++) parcor_r[k] <= 16'h0000;
			for (int k = 0; k < NB_MAX; k++) scf_r[k] <= 7'h00;
		end else begin
			aw_ok_r <= aw_ok_nxt;
			aw_a_r <= aw_a_nxt;
			w_ok_r <= w_ok_nxt;
			w_d_r <= w_d_nxt;
			w_s_r <= w_s_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			cmd_r <= cmd_nxt;
			cfg_chg_r <= cfg_chg_nxt;
			cfg_r <= cfg_nxt;
			flags_r <= flags_nxt;
			thr_lo_r <= thr_lo_nxt;
			thr_hi_r <= thr_hi_nxt;
			first_r <= first_nxt;
			nb_r <= nb_nxt;
			width_r <= width_nxt;
			tns_r <= tns_nxt;
			raw_r <= raw_nxt;
			ratio_r <= ratio_nxt;
			parcor_r <= parcor_nxt;
			scf_r <= scf_nxt;
		end
	end

	// ****************************************************
	// frame processing and coder item stream
	// ****************************************************
	assign w_go = (st_r == ST_IDLE) && cmd_r[CTRL_WHITEN];

	always_comb begin
		st_nxt = st_r;
		cod_nxt = cod_r;
		cod_valid_nxt = cod_valid_r;
		fir_nxt = fir_r;
		iir_nxt = iir_r;
		cur_nxt = cur_r;
		prevl_nxt = prevl_r;
		pscf_nxt = pscf_r;
		prior_nxt = prior_r;
		hist_nxt = hist_r;
		flat_nxt = flat_r;
		zero_nxt = zero_r;
		sh_nxt = sh_r;
		shn_nxt = shn_r;
		prod_nxt = prod_r;
		idx_nxt = idx_r;
		tc = 3'(tiles_of(cfg_r)) + 3'h1;
		mirror = (cfg_r[3:0] < 4'(NCFG)) && CFG_MIRROR[cfg_r[3:0]];
		same = 1'b0;
		diff = 1'b0;
		sm = 18'h0_0000;
		s_k = 16'h0000;
		f_eff = 16'h0000;
		i_eff = 16'h0000;
		// sign-extend first so the square keeps its full 32 bits
		kk = {{16{parcor_r[idx_r][15]}}, parcor_r[idx_r]} *
			{{16{parcor_r[idx_r][15]}}, parcor_r[idx_r]};
		om = PROD_ONE - kk[31:15];
		pm = prod_r * om;
		for (int k = 0; k < NT_MAX; k++) lv[k] = 2'h0;
		if (cod_valid_r && cod_ready) cod_valid_nxt = 1'b0;
		if (cfg_chg_r) begin
			for (int k = 0; k < NT_MAX; k++) begin
				fir_nxt[k] = 16'h0000;
				iir_nxt[k] = 16'h0000;
				cur_nxt[k] = 2'h0;
			end
		end
		case (st_r)
			ST_IDLE: begin
				if (cmd_r[CTRL_WHITEN]) begin
					for (int k = 0; k < NT_MAX; k++) begin
						// a mode switch clears levels before they are copied
						prevl_nxt[k] = flags_r[FL_P2T] ? 2'h0 : cur_r[k];
						if (flags_r[FL_P2T] || flags_r[FL_TRANS]) begin
							fir_nxt[k] = 16'h0000;
							iir_nxt[k] = 16'h0000;
						end
					end
					if (flags_r[FL_TRANS] || prior_r) begin
						for (int k = 0; k < NT_MAX; k++) lv[k] = 2'h1;
					end else if (flags_r[FL_POWER]) begin
						for (int k = 0; k < NT_MAX; k++) begin
							f_eff = flags_r[FL_P2T] ? 16'h0000 : fir_r[k];
							i_eff = flags_r[FL_P2T] ? 16'h0000 : iir_r[k];
							sm = {2'h0, ratio_r[k]} + {2'h0, f_eff} + {3'h0, i_eff[15:1]};
							s_k = (sm > {2'h0, S_CAP}) ? S_CAP : sm[15:0];
							if (k < int'(tc)) begin
								fir_nxt[k] = ratio_r[k];
								iir_nxt[k] = s_k;
								// threshold mapping keeps levels in 0..2
								lv[k] = (s_k < thr_lo_r) ? 2'h0 :
									((s_k < thr_hi_r) ? 2'h1 : 2'h2);
							end
						end
					end
					prior_nxt = flags_r[FL_TRANS];
					if (mirror && tc >= 3'h2) lv[2'(tc - 3'h1)] = lv[2'(tc - 3'h2)];
					same = !flags_r[FL_INDEP];
					for (int k = 0; k < NT_MAX; k++) begin
						if (k < int'(tc) && lv[k] != prevl_nxt[k]) same = 1'b0;
						if (k > 0 && k < int'(tc) && lv[k] != lv[k-1]) diff = 1'b1;
					end
					sh_nxt = 16'h0000;
					shn_nxt = 5'h00;
					if (same) begin
						sh_nxt = 16'h0001;
						shn_nxt = 5'h01;
					end else begin
						if (!flags_r[FL_INDEP]) shn_nxt = 5'h01;
						for (int k = 0; k < NT_MAX; k++) begin
							if (k == 0 || (diff && k < int'(tc))) begin
								// one tile code: 1 -> 0, 0 -> 10, 2 -> 11
								if (lv[k] == 2'h1) begin
									sh_nxt = {sh_nxt[14:0], 1'b0};
									shn_nxt = shn_nxt + 5'h01;
								end else begin
									sh_nxt = {sh_nxt[13:0], 1'b1, lv[k] != 2'h0};
									shn_nxt = shn_nxt + 5'h02;
								end
							end
							if (k == 0) begin
								sh_nxt = {sh_nxt[14:0], diff};
								shn_nxt = shn_nxt + 5'h01;
							end
						end
					end
					cur_nxt = lv;
					cod_nxt.op = OP_WBIT;
					st_nxt = ST_SEND;
				end else if (cmd_r[CTRL_FLAT]) begin
					prod_nxt = PROD_ONE;
					idx_nxt = 3'h0;
					st_nxt = ST_FMUL;
				end else if (cmd_r[CTRL_SCF]) begin
					if (flags_r[FL_INDEP]) hist_nxt = 1'b0;
					zero_nxt = 1'b1;
					for (int k = 0; k < NB_MAX; k++) begin
						if (k < int'(nb_r) && scf_r[k] != 7'h00) zero_nxt = 1'b0;
					end
					st_nxt = ST_SSTART;
				end else if (cmd_r[CTRL_RAW]) begin
					sh_nxt = raw_r[15:0];
					shn_nxt = (raw_r[20:16] > 5'h10) ? 5'h10 : raw_r[20:16];
					cod_nxt.op = OP_SIGN;
					st_nxt = ST_SEND;
				end
			end
			ST_SEND: begin
				if (!cod_valid_r) begin
					if (shn_r == 5'h00) begin
						st_nxt = ST_IDLE;
					end else begin
						cod_valid_nxt = 1'b1;
						cod_nxt.bit_val = sh_r[4'(shn_r - 5'h01)];
						cod_nxt.hist = hist_r;
						shn_nxt = shn_r - 5'h01;
					end
				end
			end
			ST_FMUL: begin
				prod_nxt = pm[31:15];
				idx_nxt = idx_r + 3'h1;
				if (idx_r == 3'(NPAR - 1)) st_nxt = ST_FEVAL;
			end
			ST_FEVAL: begin
				// gain below 1.15 is the product above its reciprocal
				flat_nxt = (prod_r > PROD_THR) && (tns_r < TNS_THR);
				st_nxt = ST_IDLE;
			end
			ST_SSTART: begin
				if (!cod_valid_r) begin
					cod_valid_nxt = 1'b1;
					cod_nxt = '{op: OP_START, bit_val: 1'b0, hist: hist_r};
					st_nxt = ST_SZERO;
				end
			end
			ST_SZERO: begin
				if (!cod_valid_r) begin
					cod_valid_nxt = 1'b1;
					cod_nxt = '{op: OP_SIGN, bit_val: zero_r, hist: hist_r};
					if (zero_r) hist_nxt = 1'b0;
					st_nxt = zero_r ? ST_SFIN : ST_SVEC;
				end
			end
			ST_SVEC: begin
				if (!cod_valid_r) begin
					cod_valid_nxt = 1'b1;
					// with history invalid the vector is coded as independent
					cod_nxt = '{op: OP_VECTOR, bit_val: 1'b0, hist: hist_r};
					pscf_nxt = scf_r;
					hist_nxt = 1'b1;
					st_nxt = ST_SFIN;
				end
			end
			ST_SFIN: begin
				if (!cod_valid_r) begin
					cod_valid_nxt = 1'b1;
					cod_nxt = '{op: OP_FINISH, bit_val: 1'b0, hist: hist_r};
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ST_IDLE;
			cod_r <= '{op: OP_START, bit_val: 1'b0, hist: 1'b0};
			cod_valid_r <= 1'b0;
			for (int k = 0; k < NT_MAX; k++) begin
				fir_r[k] <= 16'h0000;
				iir_r[k] <= 16'h0000;
				cur_r[k] <= 2'h0;
				prevl_r[k] <= 2'h0;
			end
			for (int k = 0; k < NB_MAX; k++) pscf_r[k] <= 7'h00;
			prior_r <= 1'b0;
			hist_r <= 1'b0;
			flat_r <= 1'b0;
			zero_r <= 1'b0;
			sh_r <= 16'h0000;
			shn_r <= 5'h00;
			prod_r <= PROD_ONE;
			idx_r <= 3'h0;
		end else begin
			st_r <= st_nxt;
			cod_r <= cod_nxt;
			cod_valid_r <= cod_valid_nxt;
			fir_r <= fir_nxt;
			iir_r <= iir_nxt;
			cur_r <= cur_nxt;
			prevl_r <= prevl_nxt;
			pscf_r <= pscf_nxt;
			prior_r <= prior_nxt;
			hist_r <= hist_nxt;
			flat_r <= flat_nxt;
			zero_r <= zero_nxt;
			sh_r <= sh_nxt;
			shn_r <= shn_nxt;
			prod_r <= prod_nxt;
			idx_r <= idx_nxt;
		end
	end

	assign awready = !aw_ok_r && !bvalid_r;
	assign wready = !w_ok_r && !bvalid_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign cod_valid = cod_valid_r;
	assign cod = cod_r;
	assign temporal_flat_flag = flat_r;
	assign zero_scale_flag = zero_r;
	for (genvar g = 0; g < NB_MAX; g++) begin : g_sf
		assign sf_cur[7*g +: 7] = scf_r[g];
		assign sf_prev[7*g +: 7] = pscf_r[g];
	end

	// ****************************************************
	// checks
	// ****************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_cfg_clear; cfg_chg_r && !w_go |=> fir_r[0] == 16'h0000 && cur_r[1] == 2'h0; endproperty
	a_cfg_clear: assert property (p_cfg_clear) else $error("switch left state");
	property p_prev_copy; w_go && !flags_r[FL_P2T] && !cfg_chg_r |=> prevl_r[0] == $past(cur_r[0]); endproperty
	a_prev_copy: assert property (p_prev_copy) else $error("previous level not copied");
	property p_force_one; w_go && flags_r[FL_TRANS] |=> cur_r[0] == 2'h1 && fir_r[0] == 16'h0000; endproperty
	a_force_one: assert property (p_force_one) else $error("transient level not one");
	property p_cap; w_go && !flags_r[FL_TRANS] && !prior_r |=> iir_r[0] <= S_CAP; endproperty
	a_cap: assert property (p_cap) else $error("smoothed value above cap");
	property p_range; cur_r[0] != 2'h3 && cur_r[NT_MAX-1] != 2'h3; endproperty
	a_range: assert property (p_range) else $error("level out of range");
	property p_len; w_go |=> shn_r >= 5'h01 && shn_r <= 5'h0A; endproperty
	a_len: assert property (p_len) else $error("whitening length wrong");
	property p_zero_stop; st_r == ST_SZERO && zero_r && !cod_valid_r |=> !hist_r && st_r == ST_SFIN; endproperty
	a_zero_stop: assert property (p_zero_stop) else $error("zero flag not final");
	property p_indep; st_r == ST_IDLE && cmd_r[CTRL_SCF] && flags_r[FL_INDEP] |=> !hist_r; endproperty
	a_indep: assert property (p_indep) else $error("independent frame kept history");
	property p_flat; $rose(flat_r) |-> tns_r < TNS_THR && prod_r > PROD_THR; endproperty
	a_flat: assert property (p_flat) else $error("flat flag without low gains");
	property p_hold; cod_valid_r && !cod_ready |=> cod_valid_r && $stable(cod_r); endproperty
	a_hold: assert property (p_hold) else $error("coder item dropped");
endmodule : gfw_encoder

// ### testbench/gfw_coder_model.sv
// stand-in for the shared coder core on the far side of the coder stream
// assumes the encoder's coder stream runs on the same clock
`timescale 1ns/1ps

module gfw_coder_model (
	input  logic aclk,
	input  logic aresetn,
	input  logic cod_valid,
	output logic cod_ready
);
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;

	// ****************************************************
	// takes start, bit, vector and finish items
	// ****************************************************
	// one stall in four offered cycles: items go prompt and slow
	always_comb begin
		cnt_nxt = cod_valid ? cnt_r + 2'h1 : cnt_r;
	end

	always_ff @(posedge aclk) begin
		cnt_r <= aresetn ? cnt_nxt : 2'h0;
	end

	assign cod_ready = (cnt_r != 2'h3);
endmodule : gfw_coder_model

// ### testbench/gfw_encoder_tb_top.sv
// bench: register tasks over the bus, coder items collected and compared
// assumes the coder model stalls ready now and then
`timescale 1ns/1ps

module gfw_encoder_tb_top;
	import gfw_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
	logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rv;
	logic [1:0] bresp, rresp, rr;
	logic awready, wready, bvalid, arready, rvalid, cod_valid, cod_ready;
	logic temporal_flat_flag, zero_scale_flag;
	logic [111:0] sf_cur, sf_prev;
	gfw_cod_t cod;
	logic [4:0] got[$], nil[$], st, fi, v0, v1, s0, s1, w0, w1;
	int bad_count = 0, total_checks = 0, cyc = 0;

	gfw_encoder i_gfw_encoder (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .cod_valid, .cod, .cod_ready,
		.sf_cur, .sf_prev, .temporal_flat_flag, .zero_scale_flag);
	gfw_coder_model i_gfw_coder_model (.aclk, .aresetn, .cod_valid, .cod_ready);

	// ****************************************************
	// helpers
	// ****************************************************
	initial forever #50 aclk = ~aclk;
	// start and finish carry no payload worth comparing
	function automatic logic [4:0] k(gfw_op_t op, logic b, logic h);
		k = (op == OP_VECTOR) ? {op, 1'h0, h} : (op == OP_START || op == OP_FINISH) ? {op, 2'h0} : {op, b, 1'h0};
	endfunction : k
	always @(posedge aclk) if (cod_valid && cod_ready) got.push_back(k(cod.op, cod.bit_val, cod.hist));
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= {a, 2'h0};
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready && awvalid) awvalid <= 1'h0;
			if (wready && wvalid) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
	endtask : wr
	task automatic rd(input logic [5:0] a);
		@(posedge aclk);
		araddr <= {a, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready && arvalid) arvalid <= 1'h0;
		end while (!rvalid);
		rv = rdata;
		rr = rresp;
		rready <= 1'h0;
	endtask : rd
	task automatic run(input int b, input logic [4:0] e[$]);
		got.delete();
		wr(A_CTRL, 32'h1 << b);
		do rd(A_STATUS); while (rv[0] !== 1'h0);
		chk(got.size(), e.size());
		foreach (e[i]) chk(got[i], e[i]);
	endtask : run
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test

	// ****************************************************
	// sequence
	// ****************************************************
	initial begin
		{st, fi, v0, v1} = {k(OP_START, 0, 0), k(OP_FINISH, 0, 0), k(OP_VECTOR, 0, 0), k(OP_VECTOR, 0, 1)};
		{s0, s1, w0, w1} = {k(OP_SIGN, 0, 0), k(OP_SIGN, 1, 0), k(OP_WBIT, 0, 0), k(OP_WBIT, 1, 0)};
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		rd(A_THR);
		chk(rv, {THR_HI_RST, THR_LO_RST});
		rd(6'h3F);
		chk(rr, RESP_ERR);
		wr(A_FLAGS, 32'h5);
		run(CTRL_WHITEN, '{w0, w0});
		wr(A_FLAGS, 32'h1);
		run(CTRL_WHITEN, '{w1});
		rd(A_STATUS);
		chk(rv[23:8], 16'h5555);
		wr(A_CFG, 32'h1);
		rd(A_STATUS);
		chk(rv[15:8], 8'h00);
		wr(A_FLAGS, 32'h0);
		run(CTRL_WHITEN, '{w0, w0, w0});
		wr(A_RAW, 32'h000800A5);
		run(CTRL_RAW, '{s1, s0, s1, s0, s0, s1, s0, s1});
		wr(A_GEOM, 32'h00040000);
		wr(A_FLAGS, 32'h4);
		run(CTRL_SCF, '{st, s1, fi});
		chk(zero_scale_flag, 1'h1);
		wr(A_SCF, 32'h00000500);
		wr(A_FLAGS, 32'h0);
		run(CTRL_SCF, '{st, s0, v0, fi});
		chk(sf_cur[6:0], 7'h05);
		run(CTRL_SCF, '{st, s0, v1, fi});
		chk(sf_prev[6:0], 7'h05);
		wr(A_FLAGS, 32'h4);
		run(CTRL_SCF, '{st, s0, v0, fi});
		wr(A_TNS, 32'h1000);
		run(CTRL_FLAT, nil);
		chk(temporal_flat_flag, 1'h1);
		wr(A_PARCOR, 32'h4000);
		run(CTRL_FLAT, nil);
		chk(temporal_flat_flag, 1'h0);
		stop_test();
	end
endmodule : gfw_encoder_tb_top
